// File: common/irde_defines.vh
// Constants for the infrared descriptor-ring engine: register offsets,
// field positions, reset values and descriptor layout.
// Assumes the includer uses the bare file name and plain Verilog-2005.
`ifndef IRDE_DEFINES_VH
`define IRDE_DEFINES_VH

// APB register offsets (byte addresses, one word each)
`define OFF_CLK_GATE 8'h00
`define OFF_STATUS_ON 8'h04
`define OFF_PKT_LIMIT 8'h08
`define OFF_PHY_SETUP 8'h0c
`define OFF_PRIMARY 8'h10
`define OFF_SECONDARY 8'h14
`define OFF_BASE_LOW 8'h18
`define OFF_BASE_HIGH 8'h1c
`define OFF_RING_LEN 8'h20
`define OFF_RING_KICK 8'h24

// Reset values
`define RST_WORD16 16'h0000
`define RST_WORD32 32'h00000000

// Peripheral clock gate register bits
`define GATE_HALF_RATE 3
`define GATE_CLK_ON 2

// Status and global-on register
`define STAT_ON_BIT 15
`define STAT_SIR_BITS 15'h0eff
`define STAT_IDLE_BITS 15'h0000

// PHY setup register fields
`define PHY_BAUD_HI 15
`define PHY_BAUD_LO 10
`define PHY_PULSE_HI 9
`define PHY_PULSE_LO 5
`define PHY_PRE_HI 4
`define PHY_PRE_LO 0

// Primary setup register bits
`define PRI_TX_ON 12
`define PRI_RX_ON 11
`define PRI_WALKER_ON 10
`define PRI_KEEP_SHORT 9
`define PRI_FIR 6
`define PRI_MIR 5
`define PRI_SIR 4
`define PRI_TX_FLIP 1
`define PRI_RX_FLIP 0

// Secondary setup register bits
`define SEC_CLK48 2
`define SEC_RX_IE 1
`define SEC_TX_IE 0

// Ring length field
`define RING_LEN_HI 6
`define RING_MAX_ENTRIES 7'h40
`define RING_LAST_IDX 6'h3f

// Transmit descriptor word 0 layout
`define TXD_CNT_HI 11
`define TXD_OWN 31
`define TXD_NO_CRC 30
`define TXD_BAD_CRC 29
`define TXD_MARKER 28
`define TXD_FORCE_UF 27
`define TXD_TX_OFF 26
`define TXD_UNDERFLOW 24

// Forced underflow stops feeding after this many bytes
`define FORCE_UF_BYTES 12'h012

// Chunk sizes within one memory word
`define WORD_BYTES 3'h4
`define BYTES_ONE 12'h001

`endif

// File: rtl/tx_byte_pump.v
// Byte pump: holds one fetched memory word and hands its bytes to the
// transmitter one at a time, lowest lane first.
// Assumes the loader only loads while idle and the transmitter handshakes.
`timescale 1ns/1ps
`include "irde_defines.vh"

module tx_byte_pump (
  input wire pclk, // Clock
  input wire presetn, // Asynchronous reset, active low
  input wire ce, // Clock enable
  input wire load, // Load a new word chunk
  input wire [31:0] word, // Fetched memory word
  input wire [1:0] lane, // First byte lane to send
  input wire [2:0] nbytes, // Bytes of this chunk, 1 to 4
  input wire mark_last, // Chunk ends the packet
  input wire tx_ready, // Transmitter takes a byte
  output wire tx_valid, // Byte on offer
  output wire [7:0] tx_data, // Byte to send
  output wire tx_last, // Last byte of the packet
  output wire byte_taken, // One byte accepted this cycle
  output wire busy // Bytes still held
);

  reg [31:0] word_q; // Held word
  reg [1:0] lane_q; // Lane on offer
  reg [2:0] left_q; // Bytes still to send
  reg last_q; // Chunk closes packet
  reg [7:0] data_q; // Byte register on the output

  // Selects a byte of a word by lane
  function [7:0] pick_byte;
    input [31:0] w;
    input [1:0] l;
    begin
      pick_byte = w[{l, 3'b000} +: 8];
    end
  endfunction

  assign busy = (left_q != 3'h0);
  assign tx_valid = busy;
  assign byte_taken = busy && tx_ready;
  assign tx_data = data_q;
  assign tx_last = last_q && (left_q == 3'h1);

  ////////////////////////////////////////////////////////////////////////
  // Load and step through the lanes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= `RST_WORD32;
      lane_q <= 2'h0;
      left_q <= 3'h0;
      last_q <= 1'b0;
      data_q <= 8'h00;
    end else if (ce) begin
      if (load) begin
        // New chunk
        word_q <= word;
        lane_q <= lane;
        left_q <= nbytes;
        last_q <= mark_last;
        data_q <= pick_byte(word, lane);
      end else if (byte_taken) begin
        // Next lane
        lane_q <= lane_q + 2'h1;
        left_q <= left_q - 3'h1;
        data_q <= pick_byte(word_q, lane_q + 2'h1);
      end
    end
  end

endmodule

// File: rtl/ir_ring_engine.v
// Descriptor-ring engine of an infrared serial controller: APB register
// file, transmit ring walker feeding bytes to the transmitter, and
// receive descriptor write-back.
// Assumes a word-wide memory port that holds a request until ack, and a
// transmitter taking bytes by valid/ready.
//
// Functional notes
// R1: Software gates clock, then disables before configuring.
// R2: Packet length register caps bytes per packet.
// R3: PHY setup splits into baud and pulse width.
// R4: Primary setup enables tx, rx, walker, modes.
// R5: Software aligns ring base on 1 KByte.
// R6: Secondary setup bit selects 48 MHz clock.
// R7: Enabled status reads 0x8EFF in slow mode.
// R8: Writing the kick register starts ring walking.
// R9: Receive ring at base, transmit at +512.
// R10: Eight-byte descriptors, up to 64, length programmable.
// R11: Twelve-bit transmit count, reserved bits zero.
// R12: Ownership flag set means send; clear after.
// R13: No-CRC flag suppresses CRC, cleared after send.
// R14: Bad-CRC flag corrupts CRC, cleared after send.
// R15: Marker flag emits pulse after packet, cleared.
// R16: Forced-underflow flag underruns packet after 18 bytes.
// R17: Tx-off flag clears transmitter enable after packet.
// R18: Underflow flag set on hardware underrun.
// R19: Data address from descriptor bytes 4 to 7.
// R20: Walk in order, halt at unowned, await kick.
// R21: Descriptor completion raises enabled done event.
// R22: Receive count is thirteen bits, bytes 0-1.
// R23: Index wraps to first entry after last.
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "irde_defines.vh"

module ir_ring_engine (
  input wire pclk, // Clock, 40 MHz
  input wire presetn, // Asynchronous reset, active low
  input wire ce, // Clock enable, freezes all state
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB write
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output wire pslverr, // APB error on unmapped address
  output wire mem_req, // Memory request, held until ack
  output wire mem_we, // Memory write
  output wire [31:0] mem_addr, // Memory byte address, word aligned
  output wire [31:0] mem_wdata, // Memory write data
  input wire [31:0] mem_rdata, // Memory read data
  input wire mem_ack, // Memory ack
  output wire tx_valid, // Transmit byte valid
  output wire [7:0] tx_data, // Transmit byte
  output wire tx_last, // Last byte of packet
  input wire tx_ready, // Transmitter takes byte
  output wire tx_no_crc, // Packet without CRC
  output wire tx_bad_crc, // Packet with corrupted CRC
  output wire tx_force_underflow, // Forced underrun pulse
  output wire marker_pulse, // Indication pulse after packet
  input wire tx_underflow_in, // Hardware underrun from transmitter
  input wire rx_done, // Received packet complete pulse
  input wire [12:0] rx_count, // Received byte count
  input wire [4:0] rx_status, // Receive error flags
  output wire rx_busy, // Receive write-back pending
  output wire tx_done_event, // Transmit descriptor done pulse
  output wire rx_done_event, // Receive descriptor done pulse
  output wire [5:0] phy_baud_div, // Baud divisor
  output wire [4:0] phy_pulse_width, // Pulse width setting
  output wire [4:0] phy_preamble, // Preamble count minus one
  output wire half_rate_clock, // Half-rate clock request
  output wire rx_on_flag, // Receiver enable
  output wire keep_short_frames, // Accept runt packets
  output wire sir_mode, // Slow infrared mode
  output wire mir_mode, // Medium infrared mode
  output wire fir_mode, // Fast infrared mode
  output wire tx_pin_flip, // Invert transmit pin
  output wire rx_pin_flip, // Invert receive pin
  output wire phy_clk48_sel // 48 MHz PHY clock select
);

  // Walker states, one-hot
  localparam [6:0] S_IDLE = 7'h01; // Waiting
  localparam [6:0] S_TXD0 = 7'h02; // Read descriptor word 0
  localparam [6:0] S_TXD1 = 7'h04; // Read descriptor word 1
  localparam [6:0] S_DATA = 7'h08; // Read a data word
  localparam [6:0] S_PUMP = 7'h10; // Send bytes of the word
  localparam [6:0] S_TXWB = 7'h20; // Write descriptor back
  localparam [6:0] S_RXWB = 7'h40; // Write receive descriptor

  reg [3:0] gate_q; // Peripheral clock gate
  reg on_q; // Global on
  reg [15:0] limit_q; // Packet length limit
  reg [15:0] phy_q; // PHY setup
  reg [15:0] pri_q; // Primary setup
  reg [15:0] sec_q; // Secondary setup
  reg [15:0] base_lo_q; // Ring base low half
  reg [15:0] base_hi_q; // Ring base high half
  reg [6:0] ring_len_q; // Ring length
  reg kick_q; // Kick pending
  reg [31:0] rdata_q; // Registered APB read data
  reg [6:0] state_q; // Walker state
  reg [5:0] tx_idx_q; // Transmit ring index
  reg [5:0] rx_idx_q; // Receive ring index
  reg [31:0] desc_q; // Descriptor word 0
  reg [31:0] ptr_q; // Data byte pointer
  reg [11:0] left_q; // Bytes not yet fetched
  reg cut_q; // Packet cut by forced underflow
  reg ur_q; // Underrun seen
  reg rx_pend_q; // Receive write-back pending
  reg [12:0] rx_cnt_q; // Latched receive count
  reg [4:0] rx_st_q; // Latched receive flags
  reg tx_ev_q; // Transmit done pulse
  reg rx_ev_q; // Receive done pulse
  reg marker_q; // Marker pulse
  reg uf_q; // Forced underrun pulse

  // Byte address of a descriptor word: receive ring at base, transmit ring 512 up
  function [31:0] desc_addr;
    input [31:0] base;
    input tx_ring;
    input [5:0] idx;
    input second;
    begin
      desc_addr = {base[31:10], tx_ring, idx, second, 2'b00}; // see R9, R10
    end
  endfunction

  // Next index with wrap at the programmed length
  function [5:0] next_idx;
    input [5:0] idx;
    input [6:0] len;
    reg [5:0] last;
    begin
      last = `RING_LAST_IDX;
      if (len != 7'h00 && len <= `RING_MAX_ENTRIES) begin
        last = len[5:0] - 6'h1;
      end
      next_idx = (idx == last) ? 6'h00 : idx + 6'h1; // see R23
    end
  endfunction

  wire [31:0] base = {base_hi_q, base_lo_q}; // Ring base
  wire wr_en = ce && psel && penable && pwrite; // Write in access phase
  wire rd_setup = ce && psel && !penable; // Read data capture
  wire gate_on = gate_q[`GATE_CLK_ON]; // Peripheral clocks on
  wire tx_run = gate_on && on_q && pri_q[`PRI_WALKER_ON] && pri_q[`PRI_TX_ON];
  wire mem_done = mem_req && mem_ack; // Memory beat finished
  wire pump_busy; // Pump holds bytes
  wire byte_taken; // Pump sent one byte
  wire tx_end = (state_q == S_TXWB) && mem_done; // Descriptor finished
  wire rx_end = (state_q == S_RXWB) && mem_done; // Receive write-back done
  wire kick_wr = wr_en && (paddr == `OFF_RING_KICK); // Kick write

  // Address decode for the error answer; reads use their own case
  function mapped;
    input [7:0] a;
    begin
      mapped = (a <= `OFF_RING_KICK) && (a[1:0] == 2'b00);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Data chunk sizing from pointer lane and bytes left
  wire [2:0] lane_room = `WORD_BYTES - {1'b0, ptr_q[1:0]}; // Bytes to word end
  wire [2:0] chunk = (left_q < {9'h000, lane_room}) ? left_q[2:0] : lane_room;
  wire [11:0] chunk12 = {9'h000, chunk}; // Chunk widened
  wire [11:0] cnt_raw = desc_q[`TXD_CNT_HI:0]; // see R11
  wire [11:0] cnt_cap = ({4'h0, cnt_raw} > limit_q) ? limit_q[11:0] : cnt_raw;
  wire force_uf = desc_q[`TXD_FORCE_UF]; // Forced underflow requested

  ////////////////////////////////////////////////////////////////////////
  // APB register writes and hardware updates
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q <= 4'h0;
      on_q <= 1'b0;
      limit_q <= `RST_WORD16;
      phy_q <= `RST_WORD16;
      pri_q <= `RST_WORD16;
      sec_q <= `RST_WORD16;
      base_lo_q <= `RST_WORD16;
      base_hi_q <= `RST_WORD16;
      ring_len_q <= 7'h00;
      kick_q <= 1'b0;
    end else if (ce) begin
      if (wr_en) begin
        case (paddr)
          `OFF_CLK_GATE: gate_q <= pwdata[3:0];
          `OFF_STATUS_ON: on_q <= pwdata[`STAT_ON_BIT];
          `OFF_PKT_LIMIT: limit_q <= pwdata[15:0]; // see R2
          `OFF_PHY_SETUP: phy_q <= pwdata[15:0]; // see R3
          `OFF_PRIMARY: pri_q <= pwdata[15:0]; // see R4
          `OFF_SECONDARY: sec_q <= pwdata[15:0]; // see R6
          `OFF_BASE_LOW: base_lo_q <= pwdata[15:0];
          `OFF_BASE_HIGH: base_hi_q <= pwdata[15:0];
          `OFF_RING_LEN: ring_len_q <= pwdata[`RING_LEN_HI:0]; // see R10
          default: ;
        endcase
      end
      // Transmitter shut off after a packet that asks for it
      if (tx_end && desc_q[`TXD_TX_OFF]) begin
        pri_q[`PRI_TX_ON] <= 1'b0; // see R17
      end
      // Kick sets pending; it wins over the halt clear
      if (kick_wr) begin
        kick_q <= 1'b1; // see R8
      end else if (state_q == S_TXD0 && mem_done && !mem_rdata[`TXD_OWN]) begin
        kick_q <= 1'b0; // see R20
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB read data, captured in the setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= `RST_WORD32;
    end else if (rd_setup) begin
      case (paddr)
        `OFF_CLK_GATE: rdata_q <= {28'h0000000, gate_q};
        `OFF_STATUS_ON: rdata_q <= {16'h0000, on_q,
          (on_q && pri_q[`PRI_SIR]) ? `STAT_SIR_BITS : `STAT_IDLE_BITS}; // see R7
        `OFF_PKT_LIMIT: rdata_q <= {16'h0000, limit_q};
        `OFF_PHY_SETUP: rdata_q <= {16'h0000, phy_q};
        `OFF_PRIMARY: rdata_q <= {16'h0000, pri_q};
        `OFF_SECONDARY: rdata_q <= {16'h0000, sec_q};
        `OFF_BASE_LOW: rdata_q <= {16'h0000, base_lo_q};
        `OFF_BASE_HIGH: rdata_q <= {16'h0000, base_hi_q};
        `OFF_RING_LEN: rdata_q <= {25'h0000000, ring_len_q};
        `OFF_RING_KICK: rdata_q <= {16'h0000, kick_q, rx_pend_q, 1'b0, rx_idx_q,
          1'b0, tx_idx_q};
        default: rdata_q <= `RST_WORD32;
      endcase
    end
  end

  assign prdata = rdata_q;
  assign pready = ce;
  assign pslverr = psel && penable && !mapped(paddr);

  ////////////////////////////////////////////////////////////////////////
  // Receive completion latch; a new event wins over the write-back clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_pend_q <= 1'b0;
      rx_cnt_q <= 13'h0000;
      rx_st_q <= 5'h00;
    end else if (ce) begin
      if (rx_done && (!rx_pend_q || rx_end)) begin
        rx_pend_q <= 1'b1;
        rx_cnt_q <= rx_count;
        rx_st_q <= rx_status;
      end else if (rx_end) begin
        rx_pend_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ring walker
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      tx_idx_q <= 6'h00;
      rx_idx_q <= 6'h00;
      desc_q <= `RST_WORD32;
      ptr_q <= `RST_WORD32;
      left_q <= 12'h000;
      cut_q <= 1'b0;
      ur_q <= 1'b0;
      tx_ev_q <= 1'b0;
      rx_ev_q <= 1'b0;
      marker_q <= 1'b0;
      uf_q <= 1'b0;
    end else if (ce) begin
      tx_ev_q <= 1'b0;
      rx_ev_q <= 1'b0;
      marker_q <= 1'b0;
      uf_q <= 1'b0;
      // Hardware underrun during the packet
      if (tx_underflow_in && (state_q == S_DATA || state_q == S_PUMP)) begin
        ur_q <= 1'b1; // see R18
      end
      case (state_q)
        S_IDLE: begin
          if (rx_pend_q && gate_on && on_q) begin
            state_q <= S_RXWB;
          end else if (kick_q && tx_run) begin
            state_q <= S_TXD0;
          end
        end
        S_TXD0: begin
          if (mem_done) begin
            desc_q <= mem_rdata;
            ur_q <= 1'b0;
            state_q <= mem_rdata[`TXD_OWN] ? S_TXD1 : S_IDLE; // see R12, R20
          end
        end
        S_TXD1: begin
          if (mem_done) begin
            ptr_q <= mem_rdata; // see R19
            // Forced underflow feeds only the first bytes
            if (force_uf && cnt_cap > `FORCE_UF_BYTES) begin
              left_q <= `FORCE_UF_BYTES; // see R16
              cut_q <= 1'b1;
            end else begin
              left_q <= cnt_cap;
              cut_q <= 1'b0;
            end
            state_q <= (cnt_cap == 12'h000) ? S_TXWB : S_DATA;
          end
        end
        S_DATA: begin
          if (mem_done) begin
            ptr_q <= ptr_q + {20'h00000, chunk12};
            left_q <= left_q - chunk12;
            state_q <= S_PUMP;
          end
        end
        S_PUMP: begin
          if (!pump_busy) begin
            if (left_q != 12'h000) begin
              state_q <= S_DATA;
            end else begin
              uf_q <= cut_q; // see R16
              state_q <= S_TXWB;
            end
          end
        end
        S_TXWB: begin
          if (mem_done) begin
            tx_idx_q <= next_idx(tx_idx_q, ring_len_q); // see R23
            tx_ev_q <= sec_q[`SEC_TX_IE]; // see R21
            marker_q <= desc_q[`TXD_MARKER]; // see R15
            state_q <= S_IDLE;
          end
        end
        S_RXWB: begin
          if (mem_done) begin
            rx_idx_q <= next_idx(rx_idx_q, ring_len_q);
            rx_ev_q <= sec_q[`SEC_RX_IE]; // see R21
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory port: address and write data by state
  wire [31:0] tx_wb = {1'b0, 3'b000, desc_q[`TXD_FORCE_UF], desc_q[`TXD_TX_OFF],
    1'b0, ur_q, 12'h000, cnt_raw}; // see R12, R13, R14, R18
  wire [31:0] rx_wb = {1'b0, rx_st_q, 2'b00, 8'h00, 3'b000, rx_cnt_q}; // see R22

  assign mem_req = (state_q == S_TXD0) || (state_q == S_TXD1) ||
    (state_q == S_DATA) || (state_q == S_TXWB) || (state_q == S_RXWB);
  assign mem_we = (state_q == S_TXWB) || (state_q == S_RXWB);
  assign mem_addr = (state_q == S_RXWB) ? desc_addr(base, 1'b0, rx_idx_q, 1'b0) :
    (state_q == S_TXD1) ? desc_addr(base, 1'b1, tx_idx_q, 1'b1) :
    (state_q == S_DATA) ? {ptr_q[31:2], 2'b00} :
    desc_addr(base, 1'b1, tx_idx_q, 1'b0);
  assign mem_wdata = (state_q == S_RXWB) ? rx_wb : tx_wb;

  ////////////////////////////////////////////////////////////////////////
  // Byte pump feeding the transmitter
  tx_byte_pump u_pump (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .load((state_q == S_DATA) && mem_done),
    .word(mem_rdata),
    .lane(ptr_q[1:0]),
    .nbytes(chunk),
    .mark_last((left_q == chunk12) && !cut_q),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_last(tx_last),
    .byte_taken(byte_taken),
    .busy(pump_busy)
  );

  // Per-packet CRC controls held through the packet
  assign tx_no_crc = desc_q[`TXD_NO_CRC]; // see R13
  assign tx_bad_crc = desc_q[`TXD_BAD_CRC]; // see R14
  assign tx_force_underflow = uf_q;
  assign marker_pulse = marker_q;
  assign tx_done_event = tx_ev_q;
  assign rx_done_event = rx_ev_q;
  assign rx_busy = rx_pend_q;

  // Configuration fields out to the PHY
  assign phy_baud_div = phy_q[`PHY_BAUD_HI:`PHY_BAUD_LO];
  assign phy_pulse_width = phy_q[`PHY_PULSE_HI:`PHY_PULSE_LO];
  assign phy_preamble = phy_q[`PHY_PRE_HI:`PHY_PRE_LO];
  assign half_rate_clock = gate_q[`GATE_HALF_RATE];
  assign rx_on_flag = pri_q[`PRI_RX_ON];
  assign keep_short_frames = pri_q[`PRI_KEEP_SHORT];
  assign sir_mode = pri_q[`PRI_SIR];
  assign mir_mode = pri_q[`PRI_MIR];
  assign fir_mode = pri_q[`PRI_FIR];
  assign tx_pin_flip = pri_q[`PRI_TX_FLIP];
  assign rx_pin_flip = pri_q[`PRI_RX_FLIP];
  assign phy_clk48_sel = sec_q[`SEC_CLK48];

endmodule

// File: tb/ir_far_side_model.sv
// Far side of the ring engine: word memory with instant ack, and a
// transmitter that stalls every other cycle. Assumes the window 0x400-0x7ff.
`timescale 1ns/1ps
module ir_far_side_model (
  input wire pclk, // Clock
  input wire mem_req, // Memory request
  input wire mem_we, // Memory write
  input wire [31:0] mem_addr, // Byte address
  input wire [31:0] mem_wdata, // Write data
  output logic [31:0] mem_rdata, // Read data
  output wire mem_ack, // Ack
  input wire tx_valid, // Byte offered
  input wire [7:0] tx_data, // Byte
  input wire tx_last, // Last byte
  input wire tx_no_crc, // No CRC
  input wire tx_bad_crc, // Corrupted CRC
  input wire marker_pulse, // Indication pulse
  input wire tx_force_underflow, // Forced underrun
  input wire tx_done_event, // Packet done
  output logic tx_ready // Transmitter ready
);
  logic [31:0] m [0:255]; // Word store
  logic [7:0] b [0:63]; // Bytes taken
  int n_byte = 0, n_last = 0, n_crc = 0, n_mark = 0, n_fu = 0, n_done = 0, n_bad = 0;
  initial tx_ready = 1'b0;
  assign mem_ack = mem_req; // Answer at once
  // An idle bus shows the inverse word, never the last one
  always @* mem_rdata = mem_req ? m[mem_addr[9:2]] : ~m[mem_addr[9:2]];
  ////////////////////////////////////////////////////////////
  // Stores write-backs and counts what the transmitter sees
  always @(posedge pclk) begin
    tx_ready <= ~tx_ready;
    if (mem_req && mem_we) m[mem_addr[9:2]] <= mem_wdata;
    if (tx_valid && tx_ready) begin
      b[n_byte] <= tx_data;
      n_byte <= n_byte + 1;
      n_last <= n_last + tx_last;
      n_crc <= n_crc + tx_no_crc;
      n_bad <= n_bad + tx_bad_crc;
    end
    n_mark <= n_mark + marker_pulse;
    n_fu <= n_fu + tx_force_underflow;
    n_done <= n_done + tx_done_event;
  end
endmodule

// File: tb/ir_ring_engine_assertions.sv
// Port checker for the ring engine. Assumes it is bound to ir_ring_engine.
`timescale 1ns/1ps
module ir_ring_engine_chk (
  input wire pclk, presetn, psel, penable, pwrite, pready, // Clock, reset, APB
  input wire [7:0] paddr, // APB address
  input wire [31:0] pwdata, mem_addr, mem_wdata, // Write data, memory
  input wire mem_req, mem_we, tx_valid, tx_ready, tx_last, // Handshakes
  input wire [7:0] tx_data, // Transmit byte
  input wire [5:0] phy_baud_div, // Baud divisor
  input wire [4:0] phy_pulse_width, // Pulse width
  input wire sir_mode, keep_short_frames, phy_clk48_sel, // Modes
  input wire marker_pulse, tx_done_event, tx_force_underflow // Pulses
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite && pready; // Write lands
  property p_phy;
    wr && paddr == 8'h0c |=> phy_baud_div == $past(pwdata[15:10])
      && phy_pulse_width == $past(pwdata[9:5]);
  endproperty
  a_phy: assert property (p_phy) else $error("phy fields wrong");
  property p_pri;
    wr && paddr == 8'h10 |=> sir_mode == $past(pwdata[4])
      && keep_short_frames == $past(pwdata[9]);
  endproperty
  a_pri: assert property (p_pri) else $error("primary bits wrong");
  property p_sec;
    wr && paddr == 8'h14 |=> phy_clk48_sel == $past(pwdata[2]);
  endproperty
  a_sec: assert property (p_sec) else $error("clock select wrong");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  a_hold: assert property (p_hold) else $error("byte dropped");
  property p_wb;
    mem_req && mem_we |-> !mem_wdata[31] && mem_addr[2:0] == 3'h0;
  endproperty
  a_wb: assert property (p_wb) else $error("bad write-back");
  property p_rd;
    mem_req && !mem_we |-> mem_addr[1:0] == 2'h0;
  endproperty
  a_rd: assert property (p_rd) else $error("unaligned read");
  property p_mark;
    marker_pulse |=> !marker_pulse;
  endproperty
  a_mark: assert property (p_mark) else $error("marker too long");
  property p_done;
    tx_done_event |=> !tx_done_event;
  endproperty
  a_done: assert property (p_done) else $error("done too long");
  property p_last;
    tx_valid && tx_ready && tx_last |=> !tx_valid [*2];
  endproperty
  a_last: assert property (p_last) else $error("byte after last");
  c_kick: cover property (wr && paddr == 8'h24);
  c_fu: cover property (tx_force_underflow);
  c_mark: cover property (marker_pulse);
endmodule
bind ir_ring_engine ir_ring_engine_chk chk_u (.*);

// File: tb/test_infrared_ring_descriptor_engine.sv
// Bench: APB set-up, then three packets through the transmit ring.
// Assumes the far-side model answers memory and takes bytes.
`timescale 1ns/1ps
module test_infrared_ring_descriptor_engine;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, uf = 0, rxd = 0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata, mem_rdata, mem_addr, mem_wdata;
  logic pready, pslverr, mem_req, mem_we, mem_ack, tx_valid, tx_last, tx_ready;
  logic tx_no_crc, tx_bad_crc, marker_pulse, tx_force_underflow, tx_done_event;
  logic rx_busy, rx_done_event, half_rate_clock, rx_on_flag, keep_short_frames;
  logic sir_mode, mir_mode, fir_mode, tx_pin_flip, rx_pin_flip, phy_clk48_sel;
  logic [7:0] tx_data;
  logic [5:0] phy_baud_div;
  logic [4:0] phy_pulse_width, phy_preamble;
  logic [7:0] wa [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h1c, 8'h20, 8'h14, 8'h04};
  logic [31:0] wd [10] = '{32'he, 32'h0, 32'h20, 32'h180, 32'h1e10, 32'h400, 32'h0,
    32'h2, 32'h5, 32'h8000};
  int miscompares = 0, check_count = 0, k;
  initial forever #12.5 pclk = ~pclk;
  ir_ring_engine dut_u (.*, .ce(1'b1), .tx_underflow_in(uf), .rx_done(rxd),
    .rx_count(13'h1abc), .rx_status(5'h15));
  ir_far_side_model u_m (.*);
  ////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Compares one value
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (i == 20) begin
      miscompares++;
      complete_run();
    end
  endtask
  // Waits for the given count of done pulses
  task automatic wt(input int n);
    int j;
    for (j = 0; j < 3000 && u_m.n_done < n; j++) @(posedge pclk);
    if (j == 3000) begin
      miscompares++;
      complete_run();
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h08, 0);
    chk("limit", 0, rd);
    for (k = 0; k < 10; k++) apb(1, wa[k], wd[k]);
    apb(0, 8'h04, 0);
    chk("status", 32'h8eff, rd);
    apb(0, 8'h28, 0);
    chk("slverr", 1, er);
    for (k = 0; k < 24; k++) u_m.m[8'hc0 + k] <= 32'h03020100 + 32'h04040404 * k;
    u_m.m[8'h80] <= 32'hd0000005;
    u_m.m[8'h81] <= 32'h701;
    u_m.m[8'h82] <= 32'h84000028;
    u_m.m[8'h83] <= 32'h710;
    apb(1, 8'h24, 0);
    wt(2);
    for (k = 0; k < 37; k++) chk("byte", k < 5 ? k + 1 : k + 11, u_m.b[k]);
    chk("last", 2, u_m.n_last);
    chk("no crc", 5, u_m.n_crc);
    chk("marker", 1, u_m.n_mark);
    chk("desc0", 5, u_m.m[8'h80]);
    chk("desc1", 32'h04, u_m.m[8'h82] >> 24);
    apb(0, 8'h10, 0);
    chk("primary", 32'h0e10, rd);
    apb(1, 8'h10, 32'h1e10);
    apb(0, 8'h10, 0);
    chk("primary", 32'h1e10, rd);
    apb(0, 8'h24, 0);
    chk("walker", 0, rd);
    u_m.m[8'h80] <= 32'ha8000014;
    u_m.m[8'h81] <= 32'h740;
    uf <= 1;
    apb(1, 8'h24, 0);
    wt(3);
    uf <= 0;
    chk("bytes", 55, u_m.n_byte);
    chk("underrun", 1, u_m.n_fu);
    chk("last", 2, u_m.n_last);
    chk("byte", 8'h51, u_m.b[54]);
    chk("desc0", 32'h09, u_m.m[8'h80] >> 24);
    chk("bad crc", 18, u_m.n_bad);
    rxd <= 1;
    @(posedge pclk);
    rxd <= 0;
    apb(0, 8'h04, 0);
    chk("status", 32'h8eff, rd);
    apb(0, 8'h24, 0);
    chk("walker", 32'h81, rd);
    chk("rx desc", 32'h54001abc, u_m.m[8'h00]);
    complete_run();
  end
endmodule
